/* File: verilog/ivt_defines.vh */
`ifndef IVT_DEFINES_VH
`define IVT_DEFINES_VH

// ------------------------------------------------------------
// address and vector layout
// ------------------------------------------------------------
`define IVT_AW 20
`define IVT_FIXED_LO 20'hf_ffdc
`define IVT_FIXED_HI 20'hf_ffff
`define IVT_VEC_UNDEF 20'hf_ffdc
`define IVT_VEC_OVFL 20'hf_ffe0
`define IVT_VEC_BREAK 20'hf_ffe4
`define IVT_VEC_AMATCH 20'hf_ffe8
`define IVT_VEC_STEP 20'hf_ffec
`define IVT_VEC_WDOG 20'hf_fff0
`define IVT_VEC_DEBUG 20'hf_fff4
`define IVT_VEC_NMI 20'hf_fff8
`define IVT_VEC_RESET 20'hf_fffc
`define IVT_BREAK_REDIRECT 16'hffff
`define IVT_ENTRY_BYTES 3'h4
`define IVT_ENTRY_LAST 2'h3
`define IVT_TABLE_BYTES 9'h100
`define IVT_FIRST_ALWAYS_NUM 6'h20

// ------------------------------------------------------------
// register map (byte addresses)
// ------------------------------------------------------------
`define IVT_REG_BASE 12'h000
`define IVT_REG_CTRL 12'h004
`define IVT_REG_LAST 12'h008
`define IVT_CAUSE_INDEX 12'h35f
`define IVT_REG_CAUSE 12'hd7c
`define IVT_BASE_RESET 20'h0_0000
`define IVT_CAUSE_LSB 4
`define IVT_CAUSE_MSB 7
`define IVT_CTRL_IEN 0
`define IVT_CTRL_AMEN 1
`define IVT_CTRL_I2C 2

// ------------------------------------------------------------
// slot layout
// ------------------------------------------------------------
`define IVT_SLOT_PERIPH_MASK 32'hffff_fff0
`define IVT_SLOT_UART2_TX 15
`define IVT_SLOT_UART2_RX 16
`define IVT_SLOT_SHARED_A 4
`define IVT_SLOT_SHARED_B 24
`define IVT_SLOT_SHARED_C 25
`define IVT_SLOT_SHARED_D 31

// ------------------------------------------------------------
// source codes reported with each branch
// ------------------------------------------------------------
`define IVT_SRC_RESET 4'h0
`define IVT_SRC_NMI 4'h1
`define IVT_SRC_WDOG 4'h2
`define IVT_SRC_DEBUG 4'h3
`define IVT_SRC_STEP 4'h4
`define IVT_SRC_AMATCH 4'h5
`define IVT_SRC_UNDEF 4'h6
`define IVT_SRC_OVFL 4'h7
`define IVT_SRC_BREAK 4'h8
`define IVT_SRC_SWINT 4'h9
`define IVT_SRC_PERIPH 4'ha

`endif

/* File: verilog/ivt_slot_map.v */
`timescale 1ns/1ps
`default_nettype none

`include "ivt_defines.vh"

module ivt_slot_map
(
  input wire [31:0] periph_irq,
  input wire [3:0] alt_irq,
  input wire [3:0] cause_select,
  input wire i2c_mode,
  input wire i2c_nack_irq,
  input wire i2c_ack_irq,
  output reg [31:0] slot_req
);

  // ------------------------------------------------------------
  // per-slot source selection
  // ------------------------------------------------------------
  wire [31:0] periph_mask = `IVT_SLOT_PERIPH_MASK;
  wire [31:0] base_req;
  genvar g;
  generate
    for (g = 0; g < 32; g = g + 1)
    begin : g_slot
      // slots below four carry no peripheral, so they are masked off
      assign base_req[g] = periph_irq[g] & periph_mask[g];
    end
  endgenerate

  // shared slots and the i2c acknowledge overlay
  always @*
  begin
    slot_req = base_req;
    slot_req[`IVT_SLOT_SHARED_A] = cause_select[0] ? alt_irq[0] : periph_irq[`IVT_SLOT_SHARED_A];
    slot_req[`IVT_SLOT_SHARED_B] = cause_select[1] ? alt_irq[1] : periph_irq[`IVT_SLOT_SHARED_B];
    slot_req[`IVT_SLOT_SHARED_C] = cause_select[2] ? alt_irq[2] : periph_irq[`IVT_SLOT_SHARED_C];
    slot_req[`IVT_SLOT_SHARED_D] = cause_select[3] ? alt_irq[3] : periph_irq[`IVT_SLOT_SHARED_D];
    if (i2c_mode)
    begin
      slot_req[`IVT_SLOT_UART2_TX] = i2c_nack_irq;
      slot_req[`IVT_SLOT_UART2_RX] = i2c_ack_irq;
    end
  end

endmodule

`default_nettype wire

/* File: verilog/ivt_vector_lookup.v */
// Chosen here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none

`include "ivt_defines.vh"


module ivt_vector_lookup
(
  input wire core_clk,
  input wire reset,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // fixed trap events from the core, one-cycle pulses
  input wire undefined_opcode_trap,
  input wire overflow_trap,
  input wire break_trap,
  input wire address_match_hit,
  input wire single_step_trap,
  input wire debugger_trap,
  input wire watchdog_irq,
  input wire nmi_req,
  // software interrupt instruction, held until acknowledged
  input wire sw_int_req,
  input wire [5:0] sw_int_num,
  output wire sw_int_ack,
  // peripheral request levels
  input wire [31:0] periph_irq,
  input wire [3:0] alt_irq,
  input wire i2c_nack_irq,
  input wire i2c_ack_irq,
  output reg [31:0] slot_ack,
  // program memory byte read port
  output reg mem_req,
  output reg [19:0] mem_addr,
  input wire mem_rvalid,
  input wire [7:0] mem_rdata,
  // branch to the core
  output reg branch_valid,
  output reg [19:0] branch_addr,
  output reg [3:0] branch_source,
  output wire busy
);

  localparam S_IDLE = 1'b0;
  localparam S_FETCH = 1'b1;

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  reg [19:0] vector_table_base;
  reg global_int_enable;
  reg address_match_enable;
  reg i2c_mode;
  reg [3:0] cause_select;
  reg [19:0] last_branch;
  reg wr_pend;
  reg [11:0] wr_addr;

  wire addr_phase = hsel & hready & htrans[1];
  wire [11:0] a_off = haddr[11:0];

  // never stalls and never errors, so the bus sees zero wait states
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // write data arrives one cycle after its address phase
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      wr_pend <= 1'b0;
      wr_addr <= 12'h000;
      vector_table_base <= `IVT_BASE_RESET;
      global_int_enable <= 1'b0;
      address_match_enable <= 1'b0;
      i2c_mode <= 1'b0;
      cause_select <= 4'h0;
    end
    else
    begin
      wr_pend <= addr_phase & hwrite;
      wr_addr <= a_off;
      if (wr_pend)
      begin
        case (wr_addr)
          `IVT_REG_BASE: vector_table_base <= hwdata[19:0];
          `IVT_REG_CTRL:
          begin
            global_int_enable <= hwdata[`IVT_CTRL_IEN];
            address_match_enable <= hwdata[`IVT_CTRL_AMEN];
            i2c_mode <= hwdata[`IVT_CTRL_I2C];
          end
          `IVT_REG_CAUSE: cause_select <= hwdata[`IVT_CAUSE_MSB:`IVT_CAUSE_LSB];
          default: ;
        endcase
      end
    end
  end

  // read data is set up in the address phase so it stands in the data phase
  always @(posedge core_clk)
  begin
    if (reset)
      hrdata <= 32'h0000_0000;
    else if (addr_phase & ~hwrite)
    begin
      case (a_off)
        `IVT_REG_BASE: hrdata <= {12'h000, vector_table_base};
        `IVT_REG_CTRL: hrdata <= {29'h0000_0000, i2c_mode, address_match_enable, global_int_enable};
        `IVT_REG_LAST: hrdata <= {12'h000, last_branch};
        `IVT_REG_CAUSE: hrdata <= {24'h00_0000, cause_select, 4'h0};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // request collection
  // ------------------------------------------------------------
  wire [31:0] slot_req;

  ivt_slot_map u_slot_map
  (
    .periph_irq(periph_irq),
    .alt_irq(alt_irq),
    .cause_select(cause_select),
    .i2c_mode(i2c_mode),
    .i2c_nack_irq(i2c_nack_irq),
    .i2c_ack_irq(i2c_ack_irq),
    .slot_req(slot_req)
  );

  // pending fixed traps: bit order matches the source codes 0..8
  reg [8:0] fixed_pend;
  reg [8:0] fixed_take;
  wire [8:0] fixed_set;
  assign fixed_set[`IVT_SRC_RESET] = 1'b0;
  assign fixed_set[`IVT_SRC_NMI] = nmi_req;
  assign fixed_set[`IVT_SRC_WDOG] = watchdog_irq;
  assign fixed_set[`IVT_SRC_DEBUG] = debugger_trap;
  assign fixed_set[`IVT_SRC_STEP] = single_step_trap;
  assign fixed_set[`IVT_SRC_AMATCH] = address_match_hit & address_match_enable;
  assign fixed_set[`IVT_SRC_UNDEF] = undefined_opcode_trap;
  assign fixed_set[`IVT_SRC_OVFL] = overflow_trap;
  assign fixed_set[`IVT_SRC_BREAK] = break_trap;

  // the reset vector is pending straight out of reset; set beats take
  always @(posedge core_clk)
  begin
    if (reset)
      fixed_pend <= 9'h001;
    else
      fixed_pend <= (fixed_pend & ~fixed_take) | fixed_set;
  end

  // peripheral slots only count while the global flag is set
  wire [31:0] periph_live = slot_req & {32{global_int_enable}};
  wire sw_ok = sw_int_req & (global_int_enable | sw_int_num == 6'h00 | sw_int_num >= `IVT_FIRST_ALWAYS_NUM);

  // ------------------------------------------------------------
  // selection: fixed traps first, then software, then lowest slot
  // ------------------------------------------------------------
  reg pick_any;
  reg [3:0] pick_src;
  reg [19:0] pick_addr;
  reg pick_fixed;
  reg [5:0] pick_num;
  integer i;

  always @*
  begin
    pick_any = 1'b0;
    pick_src = `IVT_SRC_PERIPH;
    pick_fixed = 1'b0;
    pick_num = 6'h00;
    for (i = 31; i >= 4; i = i - 1)
    begin
      if (periph_live[i])
      begin
        pick_any = 1'b1;
        pick_num = i[5:0];
      end
    end
    if (sw_ok)
    begin
      pick_any = 1'b1;
      pick_src = `IVT_SRC_SWINT;
      pick_num = sw_int_num;
    end
    for (i = 8; i >= 0; i = i - 1)
    begin
      if (fixed_pend[i])
      begin
        pick_any = 1'b1;
        pick_fixed = 1'b1;
        pick_src = i[3:0];
      end
    end
    // fixed entries do not follow source code order; each code has its own entry between 20'hf_ffdc and 20'hf_fffc
    case (pick_src)
      `IVT_SRC_RESET: pick_addr = `IVT_VEC_RESET;
      `IVT_SRC_NMI: pick_addr = `IVT_VEC_NMI;
      `IVT_SRC_WDOG: pick_addr = `IVT_VEC_WDOG;
      `IVT_SRC_DEBUG: pick_addr = `IVT_VEC_DEBUG;
      `IVT_SRC_STEP: pick_addr = `IVT_VEC_STEP;
      `IVT_SRC_AMATCH: pick_addr = `IVT_VEC_AMATCH;
      `IVT_SRC_UNDEF: pick_addr = `IVT_VEC_UNDEF;
      `IVT_SRC_OVFL: pick_addr = `IVT_VEC_OVFL;
      `IVT_SRC_BREAK: pick_addr = `IVT_VEC_BREAK;
      // relocatable entry: base plus four times the number, wraps in 20 bits
      default: pick_addr = vector_table_base + {12'h000, pick_num, 2'b00};
    endcase
  end

  // ------------------------------------------------------------
  // vector fetch state machine
  // ------------------------------------------------------------
  reg state;
  reg [1:0] byte_cnt;
  reg [23:0] shift;
  reg break_redirected;
  reg [3:0] cur_src;
  reg [5:0] cur_num;
  wire take = (state == S_IDLE) & pick_any;
  wire [31:0] entry = {mem_rdata, shift};

  assign busy = (state != S_IDLE);
  assign sw_int_ack = take & (pick_src == `IVT_SRC_SWINT);

  // one-hot take mask for the fixed pending bits
  always @*
  begin
    fixed_take = 9'h000;
    if (take & pick_fixed)
      fixed_take[pick_src] = 1'b1;
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= S_IDLE;
      byte_cnt <= 2'b00;
      shift <= 24'h00_0000;
      break_redirected <= 1'b0;
      cur_src <= `IVT_SRC_RESET;
      cur_num <= 6'h00;
      mem_req <= 1'b0;
      mem_addr <= `IVT_VEC_RESET;
      branch_valid <= 1'b0;
      branch_addr <= 20'h0_0000;
      branch_source <= `IVT_SRC_RESET;
      last_branch <= 20'h0_0000;
      slot_ack <= 32'h0000_0000;
    end
    else
    begin
      branch_valid <= 1'b0;
      slot_ack <= 32'h0000_0000;
      case (state)
        S_IDLE:
        begin
          if (take)
          begin
            state <= S_FETCH;
            byte_cnt <= 2'b00;
            break_redirected <= 1'b0;
            cur_src <= pick_src;
            cur_num <= pick_num;
            mem_req <= 1'b1;
            mem_addr <= pick_addr;
            // peripheral hears its acceptance so it can drop the request
            if (pick_src == `IVT_SRC_PERIPH)
              slot_ack[pick_num[4:0]] <= 1'b1;
          end
        end
        S_FETCH:
        begin
          if (mem_rvalid)
          begin
            // low byte arrives first and moves down as the rest follow
            shift <= {mem_rdata, shift[23:8]};
            mem_addr <= mem_addr + 20'h0_0001;
            byte_cnt <= byte_cnt + 2'b01;
            if (byte_cnt == `IVT_ENTRY_LAST)
            begin
              if (cur_src == `IVT_SRC_BREAK & ~break_redirected & entry[15:0] == `IVT_BREAK_REDIRECT)
              begin
                // unprogrammed break entry: fall back to relocatable entry 0
                break_redirected <= 1'b1;
                mem_addr <= vector_table_base;
                byte_cnt <= 2'b00;
              end
              else
              begin
                // upper twelve bits of the entry are not an address
                state <= S_IDLE;
                mem_req <= 1'b0;
                branch_valid <= 1'b1;
                branch_addr <= entry[19:0];
                branch_source <= cur_src;
                last_branch <= entry[19:0];
              end
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule

`default_nettype wire

/* File: verification/ivt_vector_lookup_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ivt_vector_lookup_checker (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic sw_int_ack,
  input wire logic [31:0] slot_ack,
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic mem_rvalid,
  input wire logic branch_valid
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // ----
  // fetch steps
  // ----
  sequence s_last_byte;
    mem_req && mem_rvalid && mem_addr[1:0] == 2'h3;
  endsequence
  sequence s_mid_byte;
    mem_req && mem_rvalid && mem_addr[1:0] != 2'h3;
  endsequence
  property p_align;
    $rose(mem_req) |-> mem_addr[1:0] == 2'h0;
  endproperty
  a_align: assert property (p_align) else $error("fetch start not aligned");
  property p_step;
    s_mid_byte |=> mem_req && mem_addr == $past(mem_addr) + 20'h0_0001;
  endproperty
  a_step: assert property (p_step) else $error("byte address did not step");
  property p_hold;
    mem_req && !mem_rvalid |=> mem_req && $stable(mem_addr);
  endproperty
  a_hold: assert property (p_hold) else $error("fetch moved without data");
  property p_end;
    s_last_byte |=> branch_valid || (mem_req && mem_addr[1:0] == 2'h0);
  endproperty
  a_end: assert property (p_end) else $error("no branch after fourth byte");
  property p_pulse;
    branch_valid |=> !branch_valid;
  endproperty
  a_pulse: assert property (p_pulse) else $error("branch pulse too long");
  // reset vector is the first fetch after release
  property p_rst_vec;
    $past(reset, 2) && !$past(reset) |-> mem_req && mem_addr == 20'hf_fffc;
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("reset vector not fetched");
  property p_fixed;
    $rose(mem_req) && mem_addr[19:8] == 12'hfff |-> mem_addr >= 20'hf_ffdc;
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed vector below area");
  property p_sw;
    sw_int_ack |=> mem_req;
  endproperty
  a_sw: assert property (p_sw) else $error("software take without fetch");
  property p_slot;
    slot_ack != 32'h0000_0000 |-> $onehot(slot_ack) && slot_ack[3:0] == 4'h0 && mem_req;
  endproperty
  a_slot: assert property (p_slot) else $error("bad slot acknowledge");
endmodule
`default_nettype wire

/* File: verification/ivt_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ivt_mem_model (
  input wire logic core_clk,
  input wire logic slow,
  input wire logic brk_ffff,
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  output wire logic mem_rvalid,
  output wire logic [7:0] mem_rdata
);
  logic tog = 1'b0;
  logic [7:0] last = 8'h00;
  logic [7:0] rd_byte;
  // every entry holds a routine address; break entry may hold the redirect code
  always @*
  begin
    rd_byte = mem_addr[7:0] ^ 8'ha5;
    if (brk_ffff && mem_addr[19:1] == 19'h7_fff2)
      rd_byte = 8'hff;
  end
  // slow mode answers every other cycle
  always @(posedge core_clk)
  begin
    tog <= ~tog;
    if (mem_rvalid)
      last <= rd_byte;
  end
  assign mem_rvalid = mem_req && (!slow || tog);
  // idle data is the inverse of the last byte, never a stale match
  assign mem_rdata = mem_rvalid ? rd_byte : ~last;
endmodule
`default_nettype wire

/* File: verification/tb_ivt_vector_lookup.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb_ivt_vector_lookup;
  typedef struct {logic [3:0] kind; logic [5:0] num; logic [19:0] vec; logic [3:0] src;} ivt_row_t;
  localparam logic [19:0] BASE = 20'h1_2340;
  int fails = 0;
  int cmp_count = 0;
  logic core_clk = 1'b0, reset = 1'b1, hsel = 1'b1, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] trap = 8'h00;
  logic sw_int_req = 1'b0, sw_int_ack, nack = 1'b0, ack = 1'b0, slow = 1'b0, brk_ffff = 1'b0;
  logic [5:0] sw_int_num = 6'h00;
  logic [31:0] periph_irq = 32'h0000_0000, slot_ack;
  logic [3:0] alt_irq = 4'h0, branch_source;
  logic mem_req, mem_rvalid, branch_valid, busy;
  logic [19:0] mem_addr, branch_addr, vec;
  logic [7:0] mem_rdata;
  ivt_row_t rows [15];
  assign hready = hreadyout;
  always #2 core_clk = ~core_clk;
  ivt_vector_lookup DUT (.core_clk(core_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .undefined_opcode_trap(trap[0]), .overflow_trap(trap[1]), .break_trap(trap[2]),
    .address_match_hit(trap[3]), .single_step_trap(trap[4]), .debugger_trap(trap[5]), .watchdog_irq(trap[6]),
    .nmi_req(trap[7]), .sw_int_req(sw_int_req), .sw_int_num(sw_int_num), .sw_int_ack(sw_int_ack),
    .periph_irq(periph_irq), .alt_irq(alt_irq), .i2c_nack_irq(nack), .i2c_ack_irq(ack), .slot_ack(slot_ack),
    .mem_req(mem_req), .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata),
    .branch_valid(branch_valid), .branch_addr(branch_addr), .branch_source(branch_source), .busy(busy));
  ivt_mem_model u_mem (.core_clk(core_clk), .slow(slow), .brk_ffff(brk_ffff), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_rvalid(mem_rvalid), .mem_rdata(mem_rdata));
  // ----
  // helpers
  // ----
  function automatic logic [19:0] routine_of(input logic [19:0] e);
    logic [7:0] b1;
    logic [7:0] b2;
    b1 = {e[7:2], 2'h1} ^ 8'ha5;
    b2 = {e[7:2], 2'h2} ^ 8'ha5;
    routine_of = {b2[3:0], b1, {e[7:2], 2'h0} ^ 8'ha5};
  endfunction
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    trap[i] <= 1'b1;
    @(posedge core_clk);
    trap[i] <= 1'b0;
  endtask
  task automatic fetch_check(input logic [19:0] v, input logic [19:0] b, input logic [3:0] s, input bit cs);
    int n;
    n = 0;
    @(posedge core_clk);
    while (mem_req !== 1'b1 && n < 100) begin @(posedge core_clk); n++; end
    if (n >= 100) fails++;
    `CHK(mem_addr, v)
    `CHK(busy, 1'b1)
    n = 0;
    while (branch_valid !== 1'b1 && n < 100) begin @(posedge core_clk); n++; end
    if (n >= 100) fails++;
    `CHK(branch_addr, b)
    `CHK(busy, 1'b0)
    if (cs) `CHK(branch_source, s)
  endtask
  task automatic quiet(input int c);
    repeat (c) begin @(posedge core_clk); `CHK({mem_req, sw_int_ack, busy, hresp}, 4'h0) end
  endtask
  task automatic wrap_up;
    if (fails == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // level requests drop once acknowledged
  always @(posedge core_clk)
  begin
    if (sw_int_ack === 1'b1) sw_int_req <= 1'b0;
    if (slot_ack != 32'h0000_0000) begin periph_irq <= '0; alt_irq <= '0; nack <= 1'b0; ack <= 1'b0; end
  end
  // hang guard
  initial
  begin
    #40000;
    fails++;
    wrap_up();
  end
  // ----
  // main sequence
  // ----
  initial
  begin
    rows = '{'{0, 0, 20'hf_ffdc, 6}, '{1, 0, 20'hf_ffe0, 7}, '{2, 0, 20'hf_ffe4, 8}, '{3, 0, 20'hf_ffe8, 5},
      '{4, 0, 20'hf_ffec, 4}, '{5, 0, 20'hf_fff4, 3}, '{6, 0, 20'hf_fff0, 2}, '{7, 0, 20'hf_fff8, 1},
      '{8, 0, 0, 9}, '{8, 63, 0, 9}, '{9, 4, 0, 10}, '{9, 31, 0, 10},
      '{9, 13, 0, 10}, '{9, 20, 0, 10}, '{9, 24, 0, 10}};
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    fetch_check(20'hf_fffc, routine_of(20'hf_fffc), 4'h0, 1);
    ahb(1, 32'h0000_0000, {12'h000, BASE});
    ahb(0, 32'h0000_0000, 0);
    `CHK(rd, {12'h000, BASE})
    ahb(1, 32'h0000_0004, 32'h0000_0003);
    ahb(1, 32'h0000_0008, 32'hffff_ffff);
    ahb(0, 32'h0000_0008, 0);
    `CHK(rd, {12'h000, routine_of(20'hf_fffc)})
    ahb(0, 32'h0000_0010, 0);
    `CHK(rd, 32'h0000_0000)
    for (int r = 0; r < 15; r++) begin
      vec = rows[r].kind < 8 ? rows[r].vec : BASE + {rows[r].num, 2'h0};
      if (rows[r].kind < 8) pulse(rows[r].kind);
      else begin @(posedge core_clk); sw_int_num <= rows[r].num;
        if (rows[r].kind == 8) sw_int_req <= 1'b1; else periph_irq[rows[r].num[4:0]] <= 1'b1; end
      fetch_check(vec, routine_of(vec), rows[r].src, 1);
    end
    brk_ffff <= 1'b1;
    pulse(2);
    fetch_check(20'hf_ffe4, routine_of(BASE), 4'h8, 0);
    brk_ffff <= 1'b0;
    slow <= 1'b1;
    ahb(1, 32'h0000_0004, 32'h0000_0000);
    pulse(3);
    quiet(10);
    sw_int_num <= 6'h28;
    sw_int_req <= 1'b1;
    fetch_check(BASE + 20'h0_00a0, routine_of(BASE + 20'h0_00a0), 4'h9, 1);
    sw_int_num <= 6'h05;
    sw_int_req <= 1'b1;
    periph_irq[10] <= 1'b1;
    quiet(10);
    ahb(1, 32'h0000_0004, 32'h0000_0001);
    fetch_check(BASE + 20'h0_0014, routine_of(BASE + 20'h0_0014), 4'h9, 1);
    fetch_check(BASE + 20'h0_0028, routine_of(BASE + 20'h0_0028), 4'ha, 1);
    ahb(1, 32'h0000_0004, 32'h0000_0005);
    nack <= 1'b1;
    fetch_check(BASE + 20'h0_003c, routine_of(BASE + 20'h0_003c), 4'ha, 1);
    ack <= 1'b1;
    fetch_check(BASE + 20'h0_0040, routine_of(BASE + 20'h0_0040), 4'ha, 1);
    ahb(1, 32'h0000_0d7c, 32'h0000_00ff);
    ahb(0, 32'h0000_0d7c, 0);
    `CHK(rd, 32'h0000_00f0)
    alt_irq <= 4'h8;
    fetch_check(BASE + 20'h0_007c, routine_of(BASE + 20'h0_007c), 4'ha, 1);
    alt_irq <= 4'h1;
    fetch_check(BASE + 20'h0_0010, routine_of(BASE + 20'h0_0010), 4'ha, 1);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    fetch_check(20'hf_fffc, routine_of(20'hf_fffc), 4'h0, 1);
    ahb(0, 32'h0000_0000, 0);
    `CHK(rd, 32'h0000_0000)
    wrap_up();
  end
endmodule
bind ivt_vector_lookup ivt_vector_lookup_checker u_chk (.core_clk(core_clk), .reset(reset),
  .sw_int_ack(sw_int_ack), .slot_ack(slot_ack), .mem_req(mem_req), .mem_addr(mem_addr),
  .mem_rvalid(mem_rvalid), .branch_valid(branch_valid));
`default_nettype wire
